// File: msa_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module msa_arbiter
  import msa_pkg::*;
#(
  parameter int unsigned REF_LIMIT = REF_PROMOTE,
  parameter int unsigned N_CH      = 4
) (
  input  wire logic              i_clock,
  input  wire logic              i_reset_n,
  // register port
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [31:0]       i_reg_wdata,
  input  wire logic              i_reg_write,
  input  wire logic              i_reg_read,
  output logic      [31:0]       o_reg_rdata,
  // cpu request path
  input  wire logic              i_cpu_req,
  input  wire logic              i_cpu_we,
  input  wire logic [31:0]       i_cpu_addr,
  input  wire logic [31:0]       i_cpu_wdata,
  output logic                   o_cpu_done,
  output logic      [31:0]       o_cpu_rdata,
  // dma channel side
  input  wire logic [N_CH-1:0]   i_dma_valid,
  input  wire logic [N_CH-1:0]   i_dma_we,
  input  wire logic [N_CH-1:0]   i_dma_last,
  input  wire logic [N_CH-1:0]   i_dma_flash,
  input  wire logic [N_CH*32-1:0] i_dma_addr,
  input  wire logic [N_CH*32-1:0] i_dma_wdata,
  output logic      [N_CH-1:0]   o_dma_ack,
  output logic      [31:0]       o_dma_rdata,
  // internal system bus requester
  input  wire logic              i_sys_req,
  input  wire logic              i_sys_we,
  input  wire logic [31:0]       i_sys_addr,
  input  wire logic [31:0]       i_sys_wdata,
  output logic                   o_sys_done,
  output logic      [31:0]       o_sys_rdata,
  // refresh request pulse
  input  wire logic              i_refresh_req,
  output logic                   o_refresh_grant,
  // memory interface
  output logic                   o_mem_valid,
  output logic                   o_mem_we,
  output logic                   o_mem_first,
  output logic                   o_mem_refresh,
  output logic      [31:0]       o_mem_addr,
  output logic      [31:0]       o_mem_wdata,
  input  wire logic              i_mem_rvalid,
  input  wire logic [31:0]       i_mem_rdata,
  // static part width select
  output logic                   o_static_parts_halfword_wide
);

  // register file
  logic [31:0] cfg_r, tim_r, mode_r, sdc_r, sts_r;
  logic [31:0] rdata_nxt;
  wire         wr_cfg  = i_reg_write && (i_reg_addr == OFS_CONFIG);
  wire         wr_clr  = i_reg_write && (i_reg_addr == OFS_STCLR);
  wire         pipe_en = cfg_r[CFG_PIPE_BIT];
  wire [N_CH-1:0] sd_en = cfg_r[CFG_SDBUF_LSB +: N_CH];
  wire [N_CH-1:0] fl_en = cfg_r[CFG_FLBUF_LSB +: N_CH];

  // read mux; unmapped offsets and the clear register read zero
  always_comb begin
    case (i_reg_addr)
      OFS_CONFIG: rdata_nxt = cfg_r;
      OFS_TIMING: rdata_nxt = tim_r;
      OFS_MODE:   rdata_nxt = mode_r;
      OFS_SDCTRL: rdata_nxt = sdc_r;
      OFS_STATUS: rdata_nxt = sts_r;
      default:    rdata_nxt = ZERO_RESET;
    endcase
  end

  // cpu pipeline stage, bypassed when the pipe bit is clear
  logic        cpq_v_r, cpq_we_r;
  logic [31:0] cpq_a_r, cpq_d_r;
  wire         cpu_v   = pipe_en ? cpq_v_r : i_cpu_req;
  wire         cpu_we  = pipe_en ? cpq_we_r : i_cpu_we;
  wire [31:0]  cpu_a   = pipe_en ? cpq_a_r : i_cpu_addr;
  wire [31:0]  cpu_d   = pipe_en ? cpq_d_r : i_cpu_wdata;

  // per-channel buffers
  logic [31:0] buf_mem [N_CH][BUF_DEPTH];
  logic [2:0]  wp_r [N_CH];
  logic [2:0]  rp_r [N_CH];
  logic [3:0]  cnt_r [N_CH];
  logic [31:0] ba_r [N_CH];      // memory address of buffer head
  logic [N_CH-1:0] flush_r;      // drain everything after last word
  logic [N_CH-1:0] rd_mode_r;
  logic [2:0]  pend_r [N_CH];    // prefetch beats still to arrive
  logic [N_CH-1:0] drop_r;       // discard beats landing after a clear

  function automatic logic ch_buffered(input int c);
    ch_buffered = i_dma_flash[c] ? fl_en[c] : sd_en[c];
  endfunction

  // need for memory service per channel
  logic [N_CH-1:0] ch_wneed, ch_rneed, ch_single, ch_urgent;
  always_comb begin
    for (int c = 0; c < N_CH; c++) begin
      ch_wneed[c]  = !rd_mode_r[c] &&
                     ((cnt_r[c] >= 4'(BURST_LEN)) || (flush_r[c] && cnt_r[c] != 4'h0));
      // one prefetch in flight at a time, never for a word already answered
      ch_rneed[c]  = i_dma_valid[c] && !i_dma_we[c] && ch_buffered(c) && !o_dma_ack[c] &&
                     (pend_r[c] == 3'h0) && (cnt_r[c] <= 4'(BUF_DEPTH - BURST_LEN));
      ch_single[c] = i_dma_valid[c] && !ch_buffered(c) && !o_dma_ack[c];
      ch_urgent[c] = flush_r[c] && ch_wneed[c];
    end
  end
  wire any_dma = |(ch_wneed | ch_rneed | ch_single);

  // refresh backlog
  logic [3:0] ref_cnt_r;
  wire        ref_promo = ref_cnt_r >= 4'(REF_LIMIT);

  // cache fill spacing
  logic [1:0] gap_r;
  wire        cpu_ok = cpu_v && (gap_r == 2'h0);

  // arbitration
  msa_state_t st_r;
  logic [1:0] last_r;            // last rotating winner
  logic [1:0] sel_r;
  logic [1:0] ch_r;
  logic [1:0] beat_r;
  logic       bwe_r;
  logic [1:0] win;
  logic       win_v;
  logic [1:0] win_ch;
  logic       win_urg;
  logic [3:0] reqv;
  always_comb begin
    reqv    = {ref_promo && (ref_cnt_r != 4'h0), i_sys_req && !o_sys_done, any_dma, cpu_ok};
    win     = REQ_REF;
    win_v   = 1'b0;
    win_ch  = 2'h0;
    win_urg = |ch_urgent;
    for (int c = N_CH - 1; c >= 0; c--)
      if (ch_urgent[c] || (!win_urg && (ch_wneed[c] | ch_rneed[c] | ch_single[c]))) win_ch = 2'(c);
    if (win_urg) begin
      win   = REQ_DMA;
      win_v = 1'b1;
    end else begin
      // rotation starts after the last winner
      for (int k = 3; k >= 1; k--) begin
        if (reqv[2'(last_r + 2'(k))]) begin
          win   = 2'(last_r + 2'(k));
          win_v = 1'b1;
        end
      end
      // the last winner still beats a low-priority refresh
      if (!win_v && reqv[last_r]) begin
        win   = last_r;
        win_v = 1'b1;
      end
      if (!win_v && ref_cnt_r != 4'h0) begin
        win   = REQ_REF;
        win_v = 1'b1;
      end
    end
  end

  wire burst_win = (win == REQ_DMA) && (ch_wneed[win_ch] || ch_rneed[win_ch]);

  // register block and cpu stage
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_r <= CFG_RESET;
      tim_r <= ZERO_RESET;
      mode_r <= ZERO_RESET;
      sdc_r <= ZERO_RESET;
      o_reg_rdata <= ZERO_RESET;
      cpq_v_r <= 1'b0;
      cpq_we_r <= 1'b0;
      cpq_a_r <= ZERO_RESET;
      cpq_d_r <= ZERO_RESET;
      o_static_parts_halfword_wide <= 1'b0;
    end else begin
      if (wr_cfg) cfg_r <= i_reg_wdata & CFG_WMASK;
      if (i_reg_write && i_reg_addr == OFS_TIMING) tim_r <= i_reg_wdata;
      if (i_reg_write && i_reg_addr == OFS_MODE) mode_r <= i_reg_wdata;
      if (i_reg_write && i_reg_addr == OFS_SDCTRL) sdc_r <= i_reg_wdata;
      o_reg_rdata <= i_reg_read ? rdata_nxt : ZERO_RESET;
      // extra cycle of latency when the stage is in use
      cpq_v_r <= i_cpu_req && !o_cpu_done && !(st_r == ST_SINGLE && sel_r == REQ_CPU);
      cpq_we_r <= i_cpu_we;
      cpq_a_r <= i_cpu_addr;
      cpq_d_r <= i_cpu_wdata;
      o_static_parts_halfword_wide <= cfg_r[CFG_X16_BIT];
    end
  end

  // status: sticky busy/flush markers, set wins over clear
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) sts_r <= ZERO_RESET;
    else sts_r <= ((wr_clr ? (sts_r & ~i_reg_wdata) : sts_r) |
                   {24'h000000, ref_promo, (st_r != ST_IDLE), 2'b00, flush_r});
  end

  // arbiter sequencer
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= ST_IDLE;
      last_r <= REQ_CPU;
      sel_r <= REQ_CPU;
      ch_r <= 2'h0;
      beat_r <= 2'h0;
      bwe_r <= 1'b0;
      gap_r <= 2'h0;
      ref_cnt_r <= 4'h0;
      o_mem_valid <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_first <= 1'b0;
      o_mem_refresh <= 1'b0;
      o_mem_addr <= ZERO_RESET;
      o_mem_wdata <= ZERO_RESET;
      o_refresh_grant <= 1'b0;
      o_cpu_done <= 1'b0;
      o_sys_done <= 1'b0;
      o_cpu_rdata <= ZERO_RESET;
      o_sys_rdata <= ZERO_RESET;
    end else begin
      o_mem_valid <= 1'b0;
      o_mem_first <= 1'b0;
      o_mem_refresh <= 1'b0;
      o_refresh_grant <= 1'b0;
      o_cpu_done <= 1'b0;
      o_sys_done <= 1'b0;
      if (gap_r != 2'h0) gap_r <= gap_r - 2'h1;
      // refresh count: grant decrements, request increments
      ref_cnt_r <= ref_cnt_r + 4'(i_refresh_req && ref_cnt_r != 4'hF)
                 - 4'(st_r == ST_IDLE && win_v && win == REQ_REF);
      case (st_r)
        ST_IDLE: begin
          if (win_v) begin
            sel_r <= win;
            ch_r <= win_ch;
            if (win != REQ_REF) last_r <= win;
            if (win == REQ_REF) begin
              o_mem_valid <= 1'b1;
              o_mem_we <= 1'b0;
              o_mem_refresh <= 1'b1;
              o_refresh_grant <= 1'b1;
            end else if (burst_win) begin
              st_r <= ST_BURST;
              beat_r <= 2'h0;
              bwe_r <= ch_wneed[win_ch];
            end else begin
              st_r <= ST_SINGLE;
              o_mem_valid <= 1'b1;
              o_mem_first <= 1'b1;
              case (win)
                REQ_CPU: begin
                  o_mem_we <= cpu_we;
                  o_mem_addr <= cpu_a;
                  o_mem_wdata <= cpu_d;
                end
                REQ_SYS: begin
                  o_mem_we <= i_sys_we;
                  o_mem_addr <= i_sys_addr;
                  o_mem_wdata <= i_sys_wdata;
                end
                default: begin
                  o_mem_we <= i_dma_we[win_ch];
                  o_mem_addr <= i_dma_addr[32*win_ch +: 32];
                  o_mem_wdata <= i_dma_wdata[32*win_ch +: 32];
                end
              endcase
            end
          end
        end
        ST_BURST: begin
          o_mem_valid <= 1'b1;
          o_mem_first <= (beat_r == 2'h0);
          o_mem_we <= bwe_r;
          o_mem_addr <= ba_r[ch_r] + {28'h0000000, beat_r, 2'b00};
          o_mem_wdata <= buf_mem[ch_r][rp_r[ch_r]];             // pointer steps per write beat while the count is nonzero
          beat_r <= beat_r + 2'h1;
          if (beat_r == 2'(BURST_LEN - 1)) st_r <= ST_IDLE;
        end
        ST_SINGLE: begin
          if (!o_mem_we ? i_mem_rvalid : 1'b1) begin
            st_r <= ST_IDLE;
            if (sel_r == REQ_CPU) begin
              o_cpu_done <= 1'b1;
              o_cpu_rdata <= i_mem_rdata;
              gap_r <= 2'(FILL_GAP);
            end
            if (sel_r == REQ_SYS) begin
              o_sys_done <= 1'b1;
              o_sys_rdata <= i_mem_rdata;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // buffer bookkeeping per channel
  wire bursting = (st_r == ST_BURST);
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int c = 0; c < N_CH; c++) begin
        wp_r[c] <= 3'h0;
        rp_r[c] <= 3'h0;
        cnt_r[c] <= 4'h0;
        ba_r[c] <= ZERO_RESET;
        pend_r[c] <= 3'h0;
        for (int e = 0; e < BUF_DEPTH; e++) buf_mem[c][e] <= ZERO_RESET;
      end
      flush_r <= '0;
      rd_mode_r <= '0;
      drop_r <= '0;
      o_dma_ack <= '0;
      o_dma_rdata <= ZERO_RESET;
    end else begin
      o_dma_ack <= '0;
      for (int c = 0; c < N_CH; c++) begin
        logic take_w, take_r, wr_out, rd_in, rd_end, keep_in, pf_go, single_done;
        logic [2:0] pend_n;
        take_w = i_dma_valid[c] && i_dma_we[c] && ch_buffered(c) && !o_dma_ack[c] &&
                 !flush_r[c] && cnt_r[c] < 4'(BUF_DEPTH);
        take_r = i_dma_valid[c] && !i_dma_we[c] && ch_buffered(c) && !o_dma_ack[c] &&
                 cnt_r[c] != 4'h0;
        // beats past the count carry stale data and leave the pointers alone
        wr_out = bursting && ch_r == 2'(c) && bwe_r && sel_r == REQ_DMA && cnt_r[c] != 4'h0;
        rd_in  = i_mem_rvalid && pend_r[c] != 3'h0 && ch_r == 2'(c);
        rd_end = take_r && i_dma_last[c];
        keep_in = rd_in && !drop_r[c] && !rd_end;
        pf_go  = st_r == ST_IDLE && burst_win && win_ch == 2'(c) && ch_rneed[c];
        pend_n = pf_go ? 3'(BURST_LEN) : 3'(pend_r[c] - 3'(rd_in));
        single_done = st_r == ST_SINGLE && sel_r == REQ_DMA && ch_r == 2'(c) &&
                      (o_mem_we || i_mem_rvalid);
        if (take_w) begin
          buf_mem[c][wp_r[c]] <= i_dma_wdata[32*c +: 32];
          wp_r[c] <= wp_r[c] + 3'h1;
          if (cnt_r[c] == 4'h0) ba_r[c] <= i_dma_addr[32*c +: 32];
          rd_mode_r[c] <= 1'b0;
          if (i_dma_last[c]) flush_r[c] <= 1'b1;
        end
        pend_r[c] <= pend_n;
        if (pf_go) begin
          rd_mode_r[c] <= 1'b1;
          if (cnt_r[c] == 4'h0) ba_r[c] <= i_dma_addr[32*c +: 32];
        end
        if (keep_in) begin
          buf_mem[c][wp_r[c]] <= i_mem_rdata;
          wp_r[c] <= wp_r[c] + 3'h1;
        end
        // head moves on by one burst, writing or prefetching
        if (bursting && ch_r == 2'(c) && sel_r == REQ_DMA && beat_r == 2'(BURST_LEN - 1))
          ba_r[c] <= ba_r[c] + 32'h00000010;
        if (wr_out) rp_r[c] <= rp_r[c] + 3'h1;
        cnt_r[c] <= 4'(cnt_r[c] + 4'(take_w | keep_in) - 4'(wr_out | take_r));
        // beats already asked for when a read ends are thrown away
        if (rd_end) drop_r[c] <= (pend_n != 3'h0);
        else if (pend_n == 3'h0) drop_r[c] <= 1'b0;
        if (take_r) begin
          o_dma_ack[c] <= 1'b1;
          o_dma_rdata <= buf_mem[c][rp_r[c]];
          rp_r[c] <= rp_r[c] + 3'h1;
          if (rd_end) begin
            cnt_r[c] <= 4'h0;
            rp_r[c] <= wp_r[c];
            rd_mode_r[c] <= 1'b0;
          end
        end
        if (take_w) o_dma_ack[c] <= 1'b1;
        if (single_done) begin
          o_dma_ack[c] <= 1'b1;
          o_dma_rdata <= i_mem_rdata;
        end
        // flush ends once the buffer has drained
        if (flush_r[c] && cnt_r[c] == 4'h0 && !take_w) flush_r[c] <= 1'b0;
      end
    end
  end

endmodule // msa_arbiter
`default_nettype wire

// File: msa_pkg.sv
package msa_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONFIG   = 8'h00;
  localparam logic [7:0] OFS_TIMING   = 8'h04;
  localparam logic [7:0] OFS_MODE     = 8'h08;
  localparam logic [7:0] OFS_SDCTRL   = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_STCLR    = 8'h14;
  // configuration fields
  localparam int unsigned CFG_PIPE_BIT   = 15;
  localparam int unsigned CFG_SDBUF_LSB  = 16;
  localparam int unsigned CFG_FLBUF_LSB  = 20;
  localparam int unsigned CFG_X16_BIT    = 24;
  localparam logic [31:0] CFG_WMASK      = 32'h01FFFFFF;
  localparam logic [31:0] CFG_RESET      = 32'h00004002;
  localparam logic [31:0] ZERO_RESET     = 32'h00000000;
  // requester indices in the rotation
  localparam logic [1:0] REQ_CPU = 2'h0;
  localparam logic [1:0] REQ_DMA = 2'h1;
  localparam logic [1:0] REQ_SYS = 2'h2;
  localparam logic [1:0] REQ_REF = 2'h3;
  // timing counts
  localparam int unsigned BURST_LEN      = 4;
  localparam int unsigned FILL_GAP       = 3;
  localparam int unsigned BUF_DEPTH      = 8;
  localparam int unsigned REF_PROMOTE    = 4;
  localparam int unsigned PIPE_MIN_MHZ   = 40;
  // arbiter states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BURST,
    ST_SINGLE
  } msa_state_t;
endpackage : msa_pkg

// File: msa_arbiter_sva.sv
`timescale 1ns/1ps
`default_nettype none
module msa_arbiter_sva
  import msa_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_reset_n,
  input wire logic [7:0]  i_reg_addr,
  input wire logic        i_reg_read,
  input wire logic [31:0] o_reg_rdata,
  input wire logic        o_cpu_done,
  input wire logic        o_sys_done,
  input wire logic        o_refresh_grant,
  input wire logic        o_mem_valid,
  input wire logic        o_mem_first,
  input wire logic        o_mem_refresh,
  input wire logic        o_static_parts_halfword_wide
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  logic       rd_q;  // read strobe one cycle back
  logic [7:0] ad_q;  // address of that read
  // track the read answer cycle
  always_ff @(posedge i_clock or negedge i_reset_n)
    if (!i_reset_n) rd_q <= 1'b0;
    else rd_q <= i_reg_read;
  // address needs no reset, only used with rd_q
  always_ff @(posedge i_clock) ad_q <= i_reg_addr;

  rdata_idle_a: assert property (!rd_q |-> o_reg_rdata == 32'h00000000)
    else $error("read data present without a read");
  unmapped_zero_a: assert property (rd_q && ad_q > OFS_STCLR |-> o_reg_rdata == 32'h00000000)
    else $error("unmapped offset returned data");
  cfg_reserved_a: assert property (rd_q && ad_q == OFS_CONFIG |-> o_reg_rdata[31:25] == 7'h00)
    else $error("reserved configuration bits not zero");
  width_copy_a: assert property (rd_q && ad_q == OFS_CONFIG |->
    o_reg_rdata[24] == o_static_parts_halfword_wide) else $error("width output differs from register");
  fill_gap_a: assert property (o_cpu_done |=> !o_cpu_done [*3])
    else $error("cpu fills closer than three cycles");
  sys_pulse_a: assert property (o_sys_done |=> !o_sys_done)
    else $error("system bus done longer than one cycle");
  start_first_a: assert property ($rose(o_mem_valid) && !o_mem_refresh |-> o_mem_first)
    else $error("memory access started without first marker");
  // a burst, once past its first beat, runs all four beats
  burst_four_a: assert property (o_mem_first ##1 (o_mem_valid && !o_mem_first) |=>
    (o_mem_valid && !o_mem_first) [*2]) else $error("burst shorter than four beats");
  cpu_done_c: cover property (o_cpu_done);
  ref_grant_c: cover property (o_refresh_grant);
  burst_c: cover property (o_mem_first ##1 (o_mem_valid && !o_mem_first));
endmodule // msa_arbiter_sva
bind msa_arbiter msa_arbiter_sva chk_u (.i_clock, .i_reset_n, .i_reg_addr, .i_reg_read, .o_reg_rdata,
  .o_cpu_done, .o_sys_done, .o_refresh_grant, .o_mem_valid, .o_mem_first, .o_mem_refresh,
  .o_static_parts_halfword_wide);
`default_nettype wire

// File: msa_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// memory behind the command port, answers each read beat
module msa_mem_model (
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  input  wire logic        i_slow,        // 1: answer after four cycles
  input  wire logic        i_cmd_valid,
  input  wire logic        i_cmd_we,
  input  wire logic        i_cmd_refresh,
  input  wire logic [31:0] i_cmd_addr,
  output logic             o_rvalid,
  output logic      [31:0] o_rdata
);
  logic [3:0]       vld_r;  // read beats in flight
  logic [3:0][31:0] adr_r;  // their addresses
  logic [31:0]      last_r; // last answer, inverted when idle
  wire  logic [1:0] tap = i_slow ? 2'h3 : 2'h0;
  // data folds the address, so a stale word cannot pass as fresh
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vld_r  <= 4'h0;
      last_r <= 32'h00000000;
    end else begin
      vld_r <= {vld_r[2:0], i_cmd_valid & ~i_cmd_we & ~i_cmd_refresh};
      if (o_rvalid) last_r <= o_rdata;
    end
  end
  always_ff @(posedge i_clock) adr_r <= {adr_r[2:0], i_cmd_addr};
  assign o_rvalid = vld_r[tap];
  assign o_rdata  = o_rvalid ? {~adr_r[tap][15:0], adr_r[tap][15:0]} : ~last_r;
endmodule // msa_mem_model
`default_nettype wire

// File: msa_arbiter_test.sv
`timescale 1ns/1ps
`default_nettype none
module test_msa_arbiter;
  import msa_pkg::*;
  localparam int unsigned LIM = 2;  // short promotion threshold
  logic        i_clock, i_reset_n, i_reg_write, i_reg_read, i_cpu_req, i_cpu_we, i_sys_req, i_sys_we;
  logic        i_refresh_req, i_slow;
  logic [7:0]  i_reg_addr;
  logic [31:0] i_reg_wdata, i_cpu_addr, i_cpu_wdata, i_sys_addr, i_sys_wdata;
  logic [3:0]  i_dma_valid, i_dma_we, i_dma_last, i_dma_flash;
  logic [127:0] i_dma_addr, i_dma_wdata;
  wire logic [31:0] o_reg_rdata, o_cpu_rdata, o_dma_rdata, o_sys_rdata, o_mem_addr, o_mem_wdata, i_mem_rdata;
  wire logic [3:0]  o_dma_ack;
  wire logic        o_cpu_done, o_sys_done, o_refresh_grant, o_mem_valid, o_mem_we, o_mem_first, o_mem_refresh;
  wire logic        o_static_parts_halfword_wide, i_mem_rvalid;
  int          n_errors, total_checks, n_ref, lat0, lat1;
  logic [31:0] wq[$];  // write beats seen on the memory port
  logic [31:0] wa[$];  // their addresses
  logic [3:0]  hist;   // done order, 1 marks the system bus
  msa_arbiter #(.REF_LIMIT(LIM)) dut_u (.i_clock, .i_reset_n, .i_reg_addr, .i_reg_wdata, .i_reg_write, .i_reg_read,
    .o_reg_rdata, .i_cpu_req, .i_cpu_we, .i_cpu_addr, .i_cpu_wdata, .o_cpu_done, .o_cpu_rdata, .i_dma_valid,
    .i_dma_we, .i_dma_last, .i_dma_flash, .i_dma_addr, .i_dma_wdata, .o_dma_ack, .o_dma_rdata, .i_sys_req,
    .i_sys_we, .i_sys_addr, .i_sys_wdata, .o_sys_done, .o_sys_rdata, .i_refresh_req, .o_refresh_grant,
    .o_mem_valid, .o_mem_we, .o_mem_first, .o_mem_refresh, .o_mem_addr, .o_mem_wdata, .i_mem_rvalid,
    .i_mem_rdata, .o_static_parts_halfword_wide);
  msa_mem_model mem_u (.i_clock, .i_reset_n, .i_slow, .i_cmd_valid(o_mem_valid), .i_cmd_we(o_mem_we),
    .i_cmd_refresh(o_mem_refresh), .i_cmd_addr(o_mem_addr), .o_rvalid(i_mem_rvalid), .o_rdata(i_mem_rdata));
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  // passive watch of memory writes, refresh grants and done order
  always @(posedge i_clock) begin
    if (o_mem_valid === 1'b1 && o_mem_we === 1'b1) begin
      wq.push_back(o_mem_wdata);
      wa.push_back(o_mem_addr);
    end
    if (o_refresh_grant === 1'b1) n_ref++;
    if (o_cpu_done === 1'b1 || o_sys_done === 1'b1) hist = {hist[2:0], o_sys_done};
  end
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {~a[15:0], a[15:0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    {i_reg_addr, i_reg_wdata, i_reg_write} <= {a, d, 1'b1};
    @(posedge i_clock);
    i_reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    {i_reg_addr, i_reg_read} <= {a, 1'b1};
    @(posedge i_clock);
    i_reg_read <= 1'b0;
    @(posedge i_clock);
    chk("register", o_reg_rdata & m, exp);
  endtask
  // request held until its done pulse is sampled
  task automatic host(input bit sys, input bit we, input logic [31:0] a, output int lat);
    lat = 0;
    if (sys) {i_sys_req, i_sys_we, i_sys_addr, i_sys_wdata} <= {1'b1, we, a, ~a};
    else {i_cpu_req, i_cpu_we, i_cpu_addr, i_cpu_wdata} <= {1'b1, we, a, ~a};
    do begin
      @(posedge i_clock);
      lat++;
    end while ((sys ? o_sys_done : o_cpu_done) !== 1'b1 && lat < 300);
    if (!we) chk("host read", sys ? o_sys_rdata : o_cpu_rdata, pat(a));
    if (sys) i_sys_req <= 1'b0;
    else i_cpu_req <= 1'b0;
    if (lat >= 300) n_errors++;
    @(posedge i_clock);
  endtask
  // one dma word, data is the inverted address
  task automatic dma(input int c, input bit we, input bit last, input logic [31:0] a);
    int n;
    n = 0;
    {i_dma_valid[c], i_dma_we[c], i_dma_last[c]} <= {1'b1, we, last};
    {i_dma_addr[32*c+:32], i_dma_wdata[32*c+:32]} <= {a, ~a};
    do begin
      @(posedge i_clock);
      n++;
    end while (o_dma_ack[c] !== 1'b1 && n < 300);
    if (!we) chk("dma read", o_dma_rdata, pat(a));
    i_dma_valid[c] <= 1'b0;
    if (n >= 300) n_errors++;
    @(posedge i_clock);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    {i_reset_n, i_reg_write, i_reg_read, i_cpu_req, i_cpu_we, i_sys_req, i_sys_we, i_refresh_req, i_slow} = 9'h000;
    {i_reg_addr, i_reg_wdata, i_cpu_addr, i_cpu_wdata, i_sys_addr, i_sys_wdata} = 168'h0;
    {i_dma_valid, i_dma_we, i_dma_last, i_dma_flash, i_dma_addr, i_dma_wdata} = 272'h0;
    hist = 4'h0;
    repeat (5) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    // reset values, storage, reserved and unmapped places
    reg_rd(OFS_CONFIG, CFG_RESET, 32'hFFFFFFFF);
    for (int i = 1; i < 5; i++) reg_rd(8'(4*i), ZERO_RESET, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++) begin
      reg_wr(8'(4*i), 32'hFFFFFFFF);
      reg_rd(8'(4*i), i == 0 ? CFG_WMASK : 32'hFFFFFFFF, 32'hFFFFFFFF);
    end
    chk("halfword width", {31'h0, o_static_parts_halfword_wide}, 32'h1);
    reg_wr(8'h18, 32'hFFFFFFFF);
    reg_rd(8'h18, ZERO_RESET, 32'hFFFFFFFF);
    reg_wr(OFS_STATUS, 32'hFFFFFFFF);
    reg_rd(OFS_STATUS, ZERO_RESET, 32'h0000000F);
    // extra cpu stage costs exactly one cycle
    reg_wr(OFS_CONFIG, 32'h00000000);
    host(0, 0, 32'h40, lat0);
    reg_wr(OFS_CONFIG, 32'h00008000);
    repeat (4) @(posedge i_clock);
    host(0, 0, 32'h40, lat1);
    chk("pipe latency", 32'(lat1), 32'(lat0 + 1));
    wq.delete();
    host(0, 1, 32'h80, lat0);
    chk("cpu write", wq[0], ~32'h80);
    // cpu and system bus compete while refresh piles up
    n_ref = 0;
    fork
      begin
        host(0, 0, 32'h100, lat0);
        host(0, 0, 32'h104, lat0);
      end
      begin
        host(1, 0, 32'h200, lat1);
        host(1, 1, 32'h204, lat1);
      end
      repeat (LIM) begin
        i_refresh_req <= 1'b1;
        @(posedge i_clock);
        i_refresh_req <= 1'b0;
        @(posedge i_clock);
      end
    join
    chk("rotation", 32'(hist[3] ^ hist[2]), 32'h1);
    repeat (20) @(posedge i_clock);
    chk("refresh grants", 32'(n_ref), 32'(LIM));
    // buffered dma writes collect four, last flushes
    reg_wr(OFS_CONFIG, 32'h00010000);
    wq.delete();
    wa.delete();
    for (int i = 0; i < 3; i++) dma(0, 1, 0, 32'h1000 + 4*i);
    repeat (10) @(posedge i_clock);
    chk("early burst", 32'(wq.size()), 32'h0);
    dma(0, 1, 0, 32'h100C);
    repeat (10) @(posedge i_clock);
    chk("burst size", 32'(wq.size()), 32'h4);
    for (int i = 0; i < 4; i++) chk("burst word", wq[i], ~(32'h1000 + 4*i));
    for (int i = 0; i < 4; i++) chk("burst addr", wa[i], 32'h1000 + 4*i);
    dma(0, 1, 0, 32'h1010);
    dma(0, 1, 1, 32'h1014);
    repeat (10) @(posedge i_clock);
    chk("flush size", 32'(wq.size()), 32'h8);
    chk("flush word", wq[5], ~32'h1014);
    reg_rd(OFS_STATUS, 32'h00000001, 32'h0000000F);
    reg_wr(OFS_STCLR, 32'h0000000F);
    reg_rd(OFS_STATUS, ZERO_RESET, 32'h0000000F);
    // unbuffered channel is one beat, flash buffer separate
    reg_wr(OFS_CONFIG, 32'h00400000);
    i_dma_flash <= 4'hC;
    wq.delete();
    dma(3, 1, 1, 32'h3000);
    repeat (10) @(posedge i_clock);
    chk("single beat", 32'(wq.size()), 32'h1);
    wq.delete();
    dma(2, 1, 1, 32'h2000);
    repeat (10) @(posedge i_clock);
    chk("flash flush", wq[0], ~32'h2000);
    // prefetching read against a slow memory, then a fresh transfer
    reg_wr(OFS_CONFIG, 32'h00020000);
    i_slow <= 1'b1;
    for (int i = 0; i < 3; i++) dma(1, 0, i == 2, 32'h500 + 4*i);
    dma(1, 0, 1, 32'h700);
    finish_test();
  end
  // hang guard, far beyond the few hundred cycles used
  initial begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    finish_test();
  end
endmodule // test_msa_arbiter
`default_nettype wire
